/* File: tb/sfd_decoder_sva.sv */
// protocol checker for the flash instruction decoder ports
`timescale 1ns/1ns
module sfd_decoder_sva #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sel_n_in,
  input wire logic [3:0] sio_oe_n_out,
  input wire logic rd_req_out,
  input wire sfd_pkg::sfd_cmd_s cmd_out,
  input wire sfd_pkg::sfd_erase_s erase_out,
  input wire logic quad_mode_out,
  input wire logic quad_pin_enable_out,
  input wire logic [7:0] burst_len_out,
  input wire logic soft_reset_out
);
  import sfd_pkg::*;
  logic [ADDR_W-17:0] blk_hi;
  logic blk_mid;
  logic blk_bot;
  // block region from address bits above 64 Kbyte
  assign blk_hi = cmd_out.addr[ADDR_W-1:16];
  assign blk_bot = (blk_hi == '0);
  assign blk_mid = !blk_bot && !(&blk_hi);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // select held high long enough to pass the synchroniser
  sequence s_deselected;
    sel_n_in [*4];
  endsequence
  // an erase fires together with its command
  sequence s_erase_fire;
    erase_out.strobe && cmd_out.strobe;
  endsequence
  AST_IDLE_RELEASE: assert property (s_deselected |-> sio_oe_n_out == 4'hF)
    else $error("lines driven while deselected");
  AST_LANE_SETS: assert property (sio_oe_n_out inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("illegal line drive set");
  AST_FOUR_LINE_OUT: assert property (quad_mode_out && sio_oe_n_out != 4'hF
    |-> sio_oe_n_out == 4'h0)
    else $error("four-line mode output not on four lines");
  AST_CMD_SPACING: assert property (cmd_out.strobe |=> !cmd_out.strobe [*8])
    else $error("command strobes too close");
  AST_ADDR_TOP: assert property (cmd_out.strobe |-> (cmd_out.addr >> ADDR_W) == 24'h0)
    else $error("address bits above array kept");
  AST_ERASE_OPC: assert property (erase_out.strobe |-> cmd_out.strobe &&
    (erase_out.sector ? cmd_out.opcode == OP_SECT : cmd_out.opcode == OP_BLK))
    else $error("erase without matching opcode");
  AST_SECT_GRAIN: assert property (s_erase_fire ##0 erase_out.sector |->
    erase_out.size_log == SECT_LOG && erase_out.base == {cmd_out.addr[23:12], 12'h000})
    else $error("sector erase granule wrong");
  AST_BLK_GRAIN: assert property (s_erase_fire ##0 !erase_out.sector |->
    erase_out.size_log == (blk_mid ? B64_LOG : (blk_bot ^ cmd_out.addr[15]) ? B8_LOG : B32_LOG))
    else $error("block erase size wrong");
  AST_RESET_STATE: assert property (soft_reset_out |=> !quad_mode_out &&
    quad_pin_enable_out == QPE_RST && burst_len_out == BURST_RST)
    else $error("state not restored by reset");
  AST_RD_PULSE: assert property (rd_req_out |=> !rd_req_out)
    else $error("read request longer than a cycle");
endmodule
bind sfd_decoder sfd_decoder_sva #(.ADDR_W(ADDR_W)) u_sva (.clk_in(clk_in), .rstn_in(rstn_in),
  .sel_n_in(sel_n_in), .sio_oe_n_out(sio_oe_n_out), .rd_req_out(rd_req_out), .cmd_out(cmd_out),
  .erase_out(erase_out), .quad_mode_out(quad_mode_out),
  .quad_pin_enable_out(quad_pin_enable_out), .burst_len_out(burst_len_out),
  .soft_reset_out(soft_reset_out));

/* File: tb/sfd_decoder_tb.sv */
// self-checking bench for the flash instruction decoder
`timescale 1ns/1ns
module sfd_decoder_tb;
  import sfd_pkg::*;
  localparam int ADDR_W = 22;
  localparam logic [23:0] AMASK = 24'h3F_FFFF;
  localparam logic [7:0] OPS [7] = '{OP_READ, OP_FREAD, OP_QOR, OP_DOR, OP_DIOR, OP_QIOR, OP_WRAP1};
  localparam int AWS [7] = '{1, 1, 1, 1, 2, 4, 4};
  localparam int DNS [7] = '{0, 1, 1, 1, 1, 3, 3};
  localparam int DWS [7] = '{1, 1, 4, 2, 2, 4, 4};
  localparam int RSS [7] = '{32, 40, 40, 40, 24, 20, 20};
  localparam logic [4:0] BSZ [4] = '{B64_LOG, B8_LOG, B32_LOG, B8_LOG};
  logic clk_in;
  logic rstn_in;
  logic [7:0] rd_data_in;
  logic sel_n, sclk, rd_req, qm, qpe, srst;
  logic [3:0] host_sio, dev_sio, dev_oe_n;
  logic [3:0] sio_w;
  logic [7:0] bl, rb, got_wr;
  sfd_cmd_s cmd, got_cmd;
  sfd_erase_s er, got_er;
  sfd_byte_s wr;
  int n_errors, num_checks, n_cmd, n_rst, n_wr, cyc, got_rises;
  logic [31:0] seed, rseed;
  logic [23:0] a;
  logic [7:0] exp_q [$];
  // device wins a line only where its enable is low
  assign sio_w = (dev_sio & ~dev_oe_n) | (host_sio & dev_oe_n);
  sfd_decoder #(.ADDR_W(ADDR_W)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sel_n_in(sel_n),
    .sclk_in(sclk), .sio_in(sio_w), .rd_data_in(rd_data_in), .sio_out(dev_sio),
    .sio_oe_n_out(dev_oe_n), .rd_req_out(rd_req), .cmd_out(cmd), .erase_out(er), .wr_out(wr),
    .quad_mode_out(qm), .quad_pin_enable_out(qpe), .burst_len_out(bl), .soft_reset_out(srst));
  sfd_host_model u_host (.clk_in(clk_in), .sio_in(sio_w), .sel_n_out(sel_n), .sclk_out(sclk),
    .sio_out(host_sio));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // capture strobes, serve read bytes, guard against a hang
  always @(posedge clk_in)
  begin
    cyc++;
    if (cmd.strobe === 1'b1)
    begin
      n_cmd++;
      got_cmd = cmd;
      got_rises = u_host.n_rise;
    end
    if (er.strobe === 1'b1) got_er = er;
    if (srst === 1'b1) n_rst++;
    if (wr.strobe === 1'b1)
    begin
      n_wr++;
      got_wr = wr.data;
    end
    if (rd_req === 1'b1)
    begin
      rd_data_in <= #2 rseed[7:0];
      exp_q.push_back(rseed[7:0]);
      rseed = xs(rseed);
    end
    if (cyc == 40000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // one frame: opcode, address, dummy, nd bytes read back; rs 0 means refused
  task automatic run(input logic [7:0] op, input int ow, input int aw, input int an,
    input int dn, input int dw, input int nd, input int rs);
    int c0;
    c0 = n_cmd;
    u_host.open_frame();
    exp_q.delete();
    u_host.xfer(op, ow, rb);
    for (int i = an - 1; i >= 0; i--) u_host.xfer(a[8 * i +: 8], aw, rb);
    for (int i = 0; i < dn; i++) u_host.xfer(8'h00, aw, rb);
    for (int i = 0; i < nd; i++)
    begin
      u_host.xfer(8'h00, dw, rb);
      check(rb, exp_q[i]);
    end
    u_host.close_frame();
    if (rs == 0) check(n_cmd, c0);
    if (rs > 0)
    begin
      check(n_cmd, c0 + 1);
      check(got_rises, rs);
      check(got_cmd.opcode, op);
      check(got_cmd.addr, a & AMASK);
    end
  endtask
  // serial write frame with n data bytes, high byte first
  task automatic wrf(input logic [7:0] op, input logic [15:0] d, input int n);
    int w0;
    w0 = n_wr;
    u_host.open_frame();
    u_host.xfer(op, 1, rb);
    for (int i = n - 1; i >= 0; i--) u_host.xfer(d[8 * i +: 8], 1, rb);
    u_host.close_frame();
    check(n_wr, w0 + n);
    check(got_wr, d[7:0]);
  endtask
  initial
  begin
    seed = 32'hf6cf_e6bf;
    rseed = xs(32'hf6cf_e6bf ^ 32'h5555_aaaa);
    rstn_in = 1'b0;
    rd_data_in = 8'h00;
    repeat (6) @(posedge clk_in);
    #2 rstn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #2;
    check(qm, 1'b0);
    check(qpe, QPE_RST);
    check(bl, BURST_RST);
    check(dev_oe_n, 4'hF);
    seed = xs(seed);
    a = {2'b11, seed[21:0]};
    run(OP_SECT, 1, 1, 3, 0, 1, 0, 32);
    check(got_er.sector, 1'b1);
    check(got_er.base, a & AMASK & 24'hFF_F000);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      a = (k == 0) ? {4'h1, seed[19:0]} : {(k == 3) ? 8'hFF : 8'h00, (k >= 2), seed[14:0]};
      run(OP_BLK, 1, 1, 3, 0, 1, 0, 32);
      check(got_er.size_log, BSZ[k]);
      check(got_er.base, a & AMASK & ~((24'h1 << BSZ[k]) - 24'h1));
    end
    $display("test erase done");
    run(OP_QOR, 1, 1, 3, 1, 4, 0, 0);
    run(OP_WRAP4, 1, 1, 3, 3, 1, 0, 0);
    u_host.open_frame();
    u_host.xfer(OP_READ, 1, rb);
    u_host.xfer(8'h12, 1, rb);
    u_host.close_frame();
    check(n_cmd, 5);
    wrf(OP_WRSR, 16'h0002, 2);
    check(qpe, 1'b1);
    // config readback shows the pin enable bit
    u_host.open_frame();
    u_host.xfer(OP_RDCR, 1, rb);
    u_host.xfer(8'h00, 1, rb);
    u_host.close_frame();
    check(rb, CFG_FIXED | (8'h01 << CFG_QPE_BIT));
    wrf(OP_BURST, 16'h0001, 1);
    check(bl, 8'(8 << 1));
    $display("test refuse and config done");
    for (int k = 0; k < 7; k++)
    begin
      seed = xs(seed);
      a = seed[23:0];
      run(OPS[k], 1, AWS[k], 3, DNS[k], DWS[k], 2, RSS[k]);
    end
    $display("test serial reads done");
    run(OP_ARM, 1, 1, 0, 0, 1, 0, -1);
    run(OP_RST, 1, 1, 0, 0, 1, 0, -1);
    check(n_rst, 1);
    check(qpe, QPE_RST);
    check(bl, BURST_RST);
    run(OP_ARM, 1, 1, 0, 0, 1, 0, -1);
    run(OP_NOP, 1, 1, 0, 0, 1, 0, -1);
    run(OP_RST, 1, 1, 0, 0, 1, 0, -1);
    check(n_rst, 1);
    run(OP_QEN, 1, 1, 0, 0, 1, 0, -1);
    check(qm, 1'b1);
    seed = xs(seed);
    a = seed[23:0];
    run(OP_FREAD, 4, 4, 3, 3, 4, 2, 14);
    run(OP_WRAP4, 4, 4, 3, 3, 4, 2, 14);
    run(OP_QOR, 4, 4, 3, 1, 4, 0, 0);
    run(OP_SECT, 4, 4, 3, 0, 4, 0, 8);
    check(got_er.base, a & AMASK & 24'hFF_F000);
    run(OP_QEXIT, 4, 4, 0, 0, 4, 0, -1);
    check(qm, 1'b0);
    run(OP_ARM, 1, 1, 0, 0, 1, 0, -1);
    run(OP_QEXIT, 1, 1, 0, 0, 1, 0, -1);
    check(qm, 1'b0);
    run(OP_RST, 1, 1, 0, 0, 1, 0, -1);
    check(n_rst, 1);
    run(OP_QEN, 1, 1, 0, 0, 1, 0, -1);
    run(OP_ARM, 4, 4, 0, 0, 4, 0, -1);
    run(OP_RST, 4, 4, 0, 0, 4, 0, -1);
    check(n_rst, 2);
    check(qm, 1'b0);
    $display("test four-line mode and reset done");
    give_verdict();
  end
endmodule

/* File: tb/sfd_host_model.sv */
// host flash controller model: select, serial clock and data lines
`timescale 1ns/1ns
module sfd_host_model (
  input wire logic clk_in,
  input wire logic [3:0] sio_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic [3:0] sio_out
);
  int n_rise;
  logic [3:0] filler;
  // deselected, clock parked low between frames
  initial
  begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    sio_out = 4'h0;
    filler = 4'h5;
    n_rise = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // select low restarts capture
  task automatic open_frame();
    tick(1);
    sel_n_out = 1'b0;
    n_rise = 0;
    tick(4);
  endtask
  task automatic close_frame();
    tick(4);
    sel_n_out = 1'b1;
    sio_out = ~sio_out;
    tick(8);
  endtask
  // one byte over w lines, msb first; idle lines toggle, sampled before the fall
  task automatic xfer(input logic [7:0] b, input int w, output logic [7:0] rb);
    logic [3:0] m;
    rb = 8'h00;
    m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (int i = 0; i < 8 / w; i++)
    begin
      filler = ~filler;
      sio_out = (filler & ~m) | (4'((b << (w * i)) >> (8 - w)) & m);
      tick(4);
      sclk_out = 1'b1;
      n_rise++;
      tick(3);
      rb = (w == 1) ? {rb[6:0], sio_in[1]} : (rb << w) | 8'(sio_in & m);
      tick(1);
      sclk_out = 1'b0;
    end
  endtask
endmodule

/* File: verilog/sfd_decoder.sv */
// serial flash opcode decoder and phase framer
`timescale 1ns/1ns
module sfd_decoder #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sel_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] sio_in,
  input wire logic [7:0] rd_data_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_n_out,
  output logic rd_req_out,
  output sfd_pkg::sfd_cmd_s cmd_out,
  output sfd_pkg::sfd_erase_s erase_out,
  output sfd_pkg::sfd_byte_s wr_out,
  output logic quad_mode_out,
  output logic quad_pin_enable_out,
  output logic [7:0] burst_len_out,
  output logic soft_reset_out
);
  import sfd_pkg::*;

  localparam logic [23:0] AMASK = 24'((25'h1 << ADDR_W) - 25'h1);
  localparam logic [23:0] AMASK_HI = AMASK >> B64_LOG;

  typedef struct packed {
    sfd_phase_e phase;
    logic csn_q;
    logic sclk_q;
    logic mode4;
    logic qpe;
    logic armed;
    logic [7:0] burst;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [1:0] bcnt;
    logic [7:0] op;
    sfd_info_s info;
    logic [23:0] addr;
    sfd_cmd_s cmd;
    sfd_erase_s erase;
    sfd_byte_s wr;
    logic rd_req;
    logic srst;
    logic [3:0] sio_o;
    logic [3:0] oe_n;
  } sfd_state_s;

  localparam sfd_state_s ST_RST = '{
    phase: PH_OPC,
    csn_q: 1'b1,
    qpe: QPE_RST,
    burst: BURST_RST,
    oe_n: 4'hF,
    default: '0
  };

  sfd_state_s s_r;
  sfd_state_s s_nxt;
  sfd_pins_s pins;

  // pins cross into the clock domain before use
  sfd_sync #(
    .W(6)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in({sel_n_in, sclk_in, sio_in}),
    .rst_val_in(6'h20),
    .q_out(pins)
  );

  // per opcode: validity, byte counts and lane widths
  function automatic sfd_info_s lookup(input logic [7:0] op, input logic m4,
                                       input logic qpe);
    sfd_info_s i;
    logic [1:0] q;
    logic [1:0] fd;
    q = m4 ? L4 : L1;
    fd = m4 ? DUM3 : DUM1;
    i = '0;
    unique case (op)
      OP_NOP, OP_ARM, OP_RST, OP_WREN, OP_WRDI, OP_CHIP, OP_SUSP, OP_RESUME:
        i = {1'b1, 2'h0, 2'h0, 1'b0, 1'b0, q, q};
      OP_QEXIT:
        i = {1'b1, 2'h0, 2'h0, 1'b0, 1'b0, q, q};
      OP_QEN:
        i = {!m4, 2'h0, 2'h0, 1'b0, 1'b0, q, q};
      OP_RDSR, OP_RDCR:
        i = {1'b1, 2'h0, m4 ? DUM1 : 2'h0, 1'b0, 1'b1, q, q};
      OP_WRSR, OP_BURST:
        i = {1'b1, 2'h0, 2'h0, 1'b1, 1'b0, q, q};
      OP_READ:
        i = {!m4, ADDR_BYTES, 2'h0, 1'b0, 1'b1, q, q};
      OP_FREAD:
        i = {1'b1, ADDR_BYTES, fd, 1'b0, 1'b1, q, q};
      OP_QOR:
        i = {!m4 & qpe, ADDR_BYTES, DUM1, 1'b0, 1'b1, L1, L4};
      OP_QIOR:
        i = {!m4 & qpe, ADDR_BYTES, DUM3, 1'b0, 1'b1, L4, L4};
      OP_DOR:
        i = {!m4, ADDR_BYTES, DUM1, 1'b0, 1'b1, L1, L2};
      OP_DIOR:
        i = {!m4, ADDR_BYTES, DUM1, 1'b0, 1'b1, L2, L2};
      OP_WRAP4:
        i = {m4, ADDR_BYTES, DUM3, 1'b0, 1'b1, L4, L4};
      OP_WRAP1:
        i = {!m4 & qpe, ADDR_BYTES, DUM3, 1'b0, 1'b1, L4, L4};
      OP_ID, OP_DISC:
        i = {!m4, op == OP_DISC ? ADDR_BYTES : 2'h0, op == OP_DISC ? DUM1 : 2'h0,
             1'b0, 1'b1, q, q};
      OP_QID:
        i = {m4, 2'h0, DUM1, 1'b0, 1'b1, q, q};
      OP_SECT, OP_BLK:
        i = {1'b1, ADDR_BYTES, 2'h0, 1'b0, 1'b0, q, q};
      OP_PP:
        i = {1'b1, ADDR_BYTES, 2'h0, 1'b1, 1'b0, q, q};
      OP_QPP:
        i = {!m4 & qpe, ADDR_BYTES, 2'h0, 1'b1, 1'b0, L1, L4};
      default:
        i = '0;
    endcase
    return i;
  endfunction

  // block granule: the 64 KB at each array end splits into 32 KB and 8 KB
  function automatic logic [4:0] blk_log(input logic [23:0] a);
    logic [23:0] hi;
    logic edge_lo;
    logic edge_hi;
    hi = a >> B64_LOG;
    edge_lo = (hi == 24'h0);
    edge_hi = (hi == AMASK_HI);
    if (edge_lo)
      return a[BOOT_SPLIT_BIT] ? B32_LOG : B8_LOG;
    else if (edge_hi)
      return a[BOOT_SPLIT_BIT] ? B8_LOG : B32_LOG;
    else
      return B64_LOG;
  endfunction

  logic rise;
  logic fall;
  logic [1:0] lane;
  logic [2:0] last_bit;
  logic [7:0] sin;
  logic [7:0] xout;
  logic [7:0] cfg_byte;
  sfd_info_s inf;
  sfd_info_s cur;
  sfd_phase_e tail;
  logic go;
  logic [23:0] am;
  logic [4:0] elog;

  // next state of the whole decoder
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cmd.strobe = 1'b0;
    s_nxt.erase.strobe = 1'b0;
    s_nxt.wr.strobe = 1'b0;
    s_nxt.rd_req = 1'b0;
    s_nxt.srst = 1'b0;
    s_nxt.csn_q = pins.csn;
    s_nxt.sclk_q = pins.sclk;
    rise = pins.sclk & ~s_r.sclk_q;
    fall = ~pins.sclk & s_r.sclk_q;
    go = 1'b0;
    inf = '0;
    cur = s_r.info;
    // lanes of the phase in flight
    unique case (s_r.phase)
      PH_OPC: lane = s_r.mode4 ? L4 : L1;
      PH_ADDR, PH_DUMMY: lane = s_r.info.al;
      default: lane = s_r.info.dl;
    endcase
    last_bit = 3'(3'h7 >> lane);
    unique case (lane)
      L2: sin = {s_r.sh[5:0], pins.sio[1:0]};
      L4: sin = {s_r.sh[3:0], pins.sio};
      default: sin = {s_r.sh[6:0], pins.sio[0]};
    endcase
    cfg_byte = CFG_FIXED;
    cfg_byte[CFG_QPE_BIT] = s_r.qpe;
    xout = (s_r.bitn == 3'h0) ? ((s_r.op == OP_RDCR) ? cfg_byte : rd_data_in) : s_r.sh;
    if (s_r.phase == PH_OPC)
      cur = lookup(sin, s_r.mode4, s_r.qpe);
    tail = cur.dout ? PH_DOUT : (cur.din ? PH_DIN : PH_SKIP);
    if (pins.csn)
    begin
      // select high ends the frame and rearms opcode capture
      s_nxt.phase = PH_OPC;
      s_nxt.bitn = 3'h0;
      s_nxt.bcnt = 2'h0;
      s_nxt.sh = 8'h00;
      s_nxt.oe_n = 4'hF;
      s_nxt.sio_o = 4'h0;
    end
    else if (rise)
    begin
      if (s_r.phase != PH_DOUT)
        s_nxt.sh = sin;
      s_nxt.bitn = (s_r.bitn == last_bit) ? 3'h0 : s_r.bitn + 3'h1;
      if (s_r.bitn == last_bit)
      begin
        s_nxt.bcnt = (s_r.bcnt == 2'h3) ? 2'h3 : s_r.bcnt + 2'h1;
        unique case (s_r.phase)
          PH_OPC:
          begin
            inf = cur;
            s_nxt.op = sin;
            s_nxt.info = inf;
            s_nxt.bcnt = 2'h0;
            s_nxt.addr = 24'h0;
            if (!inf.ok)
              s_nxt.phase = PH_SKIP;
            else
            begin
              s_nxt.armed = (sin == OP_ARM);
              if (sin == OP_RST && s_r.armed)
              begin
                s_nxt.srst = 1'b1;
                s_nxt.mode4 = 1'b0;
                s_nxt.burst = BURST_RST;
                s_nxt.qpe = QPE_RST;
              end
              if (sin == OP_QEN)
                s_nxt.mode4 = 1'b1;
              if (sin == OP_QEXIT)
                s_nxt.mode4 = 1'b0;
              if (inf.na != 2'h0)
                s_nxt.phase = PH_ADDR;
              else if (inf.nd != 2'h0)
                s_nxt.phase = PH_DUMMY;
              else
              begin
                s_nxt.phase = tail;
                go = 1'b1;
              end
            end
          end
          PH_ADDR:
          begin
            s_nxt.addr = {s_r.addr[15:0], sin};
            if (s_r.bcnt == s_r.info.na - 2'h1)
            begin
              s_nxt.bcnt = 2'h0;
              if (s_r.info.nd != 2'h0)
                s_nxt.phase = PH_DUMMY;
              else
              begin
                s_nxt.phase = tail;
                go = 1'b1;
              end
            end
          end
          PH_DUMMY:
          begin
            if (s_r.bcnt == s_r.info.nd - 2'h1)
            begin
              s_nxt.bcnt = 2'h0;
              s_nxt.phase = tail;
              go = 1'b1;
            end
          end
          PH_DIN:
          begin
            s_nxt.wr.strobe = 1'b1;
            s_nxt.wr.data = sin;
            if (s_r.op == OP_WRSR && s_r.bcnt == 2'h1)
              s_nxt.qpe = sin[CFG_QPE_BIT];
            if (s_r.op == OP_BURST && s_r.bcnt == 2'h0)
              s_nxt.burst = 8'(BURST_RST << sin[1:0]);
          end
          PH_DOUT:
            s_nxt.rd_req = 1'b1;
          default:
            s_nxt.bcnt = 2'h0;
        endcase
      end
    end
    else if (fall && s_r.phase == PH_DOUT)
    begin
      // drive on the falling edge, top bits first
      unique case (lane)
        L2:
        begin
          s_nxt.sio_o = {2'b00, xout[7:6]};
          s_nxt.oe_n = 4'b1100;
          s_nxt.sh = {xout[5:0], 2'b00};
        end
        L4:
        begin
          s_nxt.sio_o = xout[7:4];
          s_nxt.oe_n = 4'b0000;
          s_nxt.sh = {xout[3:0], 4'h0};
        end
        default:
        begin
          s_nxt.sio_o = {2'b00, xout[7], 1'b0};
          s_nxt.oe_n = 4'b1101;
          s_nxt.sh = {xout[6:0], 1'b0};
        end
      endcase
    end
    // announce the command once its address and dummy are in
    am = s_nxt.addr & AMASK;
    elog = (s_nxt.op == OP_SECT) ? SECT_LOG : blk_log(am);
    if (go)
    begin
      s_nxt.cmd.strobe = 1'b1;
      s_nxt.cmd.opcode = s_nxt.op;
      s_nxt.cmd.addr = am;
      s_nxt.rd_req = (tail == PH_DOUT);
      if (s_nxt.op == OP_SECT || s_nxt.op == OP_BLK)
      begin
        s_nxt.erase.strobe = 1'b1;
        s_nxt.erase.sector = (s_nxt.op == OP_SECT);
        s_nxt.erase.size_log = elog;
        s_nxt.erase.base = am & 24'(~((25'h1 << elog) - 25'h1));
      end
    end
  end

  // single state register
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      s_r <= ST_RST;
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state flops
  assign sio_out = s_r.sio_o;
  assign sio_oe_n_out = s_r.oe_n;
  assign rd_req_out = s_r.rd_req;
  assign cmd_out = s_r.cmd;
  assign erase_out = s_r.erase;
  assign wr_out = s_r.wr;
  assign quad_mode_out = s_r.mode4;
  assign quad_pin_enable_out = s_r.qpe;
  assign burst_len_out = s_r.burst;
  assign soft_reset_out = s_r.srst;
endmodule

/* File: verilog/sfd_pkg.sv */
// shared constants and types for the serial flash instruction decoder
package sfd_pkg;
  // opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_ARM = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_QEN = 8'h38;
  localparam logic [7:0] OP_QEXIT = 8'hFF;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDCR = 8'h35;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIOR = 8'hEB;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_BURST = 8'hC0;
  localparam logic [7:0] OP_WRAP4 = 8'h0C;
  localparam logic [7:0] OP_WRAP1 = 8'hEC;
  localparam logic [7:0] OP_ID = 8'h9F;
  localparam logic [7:0] OP_QID = 8'hAF;
  localparam logic [7:0] OP_DISC = 8'h5A;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLK = 8'hD8;
  localparam logic [7:0] OP_CHIP = 8'hC7;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SUSP = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  // lane width codes, log2 of lines used
  localparam logic [1:0] L1 = 2'h0;
  localparam logic [1:0] L2 = 2'h1;
  localparam logic [1:0] L4 = 2'h2;
  // byte counts per phase
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [1:0] DUM1 = 2'h1;
  localparam logic [1:0] DUM3 = 2'h3;
  // values after reset
  localparam logic [7:0] BURST_RST = 8'h08;
  localparam logic QPE_RST = 1'b0;
  localparam logic [7:0] CFG_FIXED = 8'h08;
  localparam int CFG_QPE_BIT = 1;
  // erase granules as log2 of bytes
  localparam logic [4:0] SECT_LOG = 5'h0C;
  localparam logic [4:0] B64_LOG = 5'h10;
  localparam logic [4:0] B32_LOG = 5'h0F;
  localparam logic [4:0] B8_LOG = 5'h0D;
  localparam int BOOT_SPLIT_BIT = 15;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_DIN = 3'b011,
    PH_DOUT = 3'b100,
    PH_SKIP = 3'b101
  } sfd_phase_e;

  typedef struct packed {
    logic ok;
    logic [1:0] na;
    logic [1:0] nd;
    logic din;
    logic dout;
    logic [1:0] al;
    logic [1:0] dl;
  } sfd_info_s;

  typedef struct packed {
    logic csn;
    logic sclk;
    logic [3:0] sio;
  } sfd_pins_s;

  typedef struct packed {
    logic strobe;
    logic [7:0] opcode;
    logic [23:0] addr;
  } sfd_cmd_s;

  typedef struct packed {
    logic strobe;
    logic sector;
    logic [23:0] base;
    logic [4:0] size_log;
  } sfd_erase_s;

  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } sfd_byte_s;
endpackage

/* File: verilog/sfd_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sfd_sync #(
  parameter int W = 6
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] rst_val_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfd_sync_s;

  sfd_sync_s s_r;
  sfd_sync_s s_nxt;

  // first stage feeds only the second
  always_comb
  begin
    s_nxt.s1 = d_in;
    s_nxt.s2 = s_r.s1;
  end

  // reset loads the idle level given by the parent constant
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      s_r.s1 <= rst_val_in;
      s_r.s2 <= rst_val_in;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.s2;
endmodule
